// >>> common/wool_map.vh
`ifndef WOOL_MAP_VH
`define WOOL_MAP_VH
// Register addresses
`define WOOL_ADDR_LATCH_TWO 16'h001D
`define WOOL_ADDR_LATCH_ONE 16'h001F
// option_latch_one fields
`define WOOL_L1_WDOG_RATE 7
`define WOOL_L1_LV_STOP_EN 6
`define WOOL_L1_LV_RST_DIS 5
`define WOOL_L1_LV_PWR_DIS 4
`define WOOL_L1_SHORT_REC 3
`define WOOL_L1_STOP_EN 1
`define WOOL_L1_WDOG_DIS 0
// option_latch_two fields
`define WOOL_L2_RC_STOP_DIS 7
`define WOOL_L2_XTAL_STOP_EN 6
`define WOOL_L2_DIV_BYPASS 5
`define WOOL_L2_PORT_HI_LCD 3
`define WOOL_L2_PORT_LO_LCD 2
`define WOOL_L2_TRIP_HI 1
`define WOOL_L2_TRIP_LO 0
// Reset values
`define WOOL_L1_RESET 8'h10
`define WOOL_L2_RESET 8'h00
`define WOOL_TRIP_RESET 2'h0
// Trip mode encodings
`define WOOL_TRIP_RSVD_2V5 2'h0
`define WOOL_TRIP_3V 2'h1
`define WOOL_TRIP_5V 2'h2
`define WOOL_TRIP_RSVD 2'h3
// Timing, in internal clock cycles
`define WOOL_WDOG_SHORT_CYC 32'h0000_1FF0
`define WOOL_WDOG_LONG_CYC 32'h0003_FFF0
`define WOOL_REC_SHORT_CYC 13'h0020
`define WOOL_REC_LONG_CYC 13'h1000
`endif

// >>> src/wool_option_latches.v
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "wool_map.vh"
module wool_option_latches (
   input wire clk,
   input wire nrst,
   input wire porRst_n,
   input wire [15:0] busAddr,
   input wire [7:0] busWrData,
   input wire busWrStb,
   input wire busRdStb,
   output reg [7:0] busRdData,
   input wire stopMode,
   input wire stopExitByReset,
   input wire lowVoltageResetReq,
   input wire baseClockSelect,
   output wire watchdogRateBit,
   output wire [31:0] watchdogTimeoutCycles,
   output wire watchdogEnable,
   output wire lowVoltageInhibitOn,
   output wire lowVoltageResetOut,
   output wire [12:0] stopRecoveryCycles,
   output wire stopIllegalOpcode,
   output wire rcOscRun,
   output wire crystalRun,
   output wire dividerBypass,
   output wire portHighNibbleLcd,
   output wire portLowNibbleLcd,
   output wire [1:0] tripModeField,
   output wire tripModeValid,
   output wire latchOneWritten,
   output wire latchTwoWritten
);
   // ********************************
   // Register storage
   // ********************************
   reg [7:0] latchOne_reg;
   reg [5:0] latchTwoLow_reg;
   reg [1:0] tripMode_reg;
   reg oneDone_reg;
   reg twoDone_reg;
   reg tripDone_reg;
   reg exitReset_reg;
   wire selOne;
   wire selTwo;
   wire [7:0] latchTwo;

   function isAddr;
      input [15:0] a;
      input [15:0] refAddr;
      begin
         isAddr = (a == refAddr);
      end
   endfunction

   assign selOne = isAddr(busAddr, `WOOL_ADDR_LATCH_ONE);
   assign selTwo = isAddr(busAddr, `WOOL_ADDR_LATCH_TWO);
   assign latchTwo = {latchTwoLow_reg, tripMode_reg};

   // Only nrst re-arms the ordinary latches; porRst_n alone leaves them as they are
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latchOne_reg <= `WOOL_L1_RESET;
         latchTwoLow_reg <= 6'h00;
         oneDone_reg <= 1'b0;
         twoDone_reg <= 1'b0;
      end else begin
         if (busWrStb && selOne && !oneDone_reg) begin
            latchOne_reg <= busWrData;
            oneDone_reg <= 1'b1;
         end
         if (busWrStb && selTwo && !twoDone_reg) begin
            latchTwoLow_reg <= busWrData[7:2];
            twoDone_reg <= 1'b1;
         end
      end
   end

   // Trip field survives ordinary resets; only power-on re-arms it
   always @(posedge clk or negedge porRst_n) begin
      if (!porRst_n) begin
         tripMode_reg <= `WOOL_TRIP_RESET;
         tripDone_reg <= 1'b0;
      end else if (busWrStb && selTwo && !tripDone_reg) begin
         tripMode_reg <= busWrData[1:0];
         tripDone_reg <= 1'b1;
      end
   end

   // ********************************
   // Read port
   // ********************************
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busRdData <= 8'h00;
      end else if (busRdStb && selOne) begin
         busRdData <= latchOne_reg;
      end else if (busRdStb && selTwo) begin
         busRdData <= latchTwo;
      end else begin
         busRdData <= 8'h00;
      end
   end

   // Remember whether the last stop exit came via reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exitReset_reg <= 1'b1;
      end else if (stopMode) begin
         exitReset_reg <= stopExitByReset;
      end
   end

   // ********************************
   // Option decode
   // ********************************
   assign watchdogRateBit = latchOne_reg[`WOOL_L1_WDOG_RATE];
   assign watchdogTimeoutCycles = watchdogRateBit ?
      `WOOL_WDOG_SHORT_CYC : `WOOL_WDOG_LONG_CYC;
   assign watchdogEnable = !latchOne_reg[`WOOL_L1_WDOG_DIS];
   assign lowVoltageInhibitOn = !latchOne_reg[`WOOL_L1_LV_PWR_DIS] &&
      (!stopMode || latchOne_reg[`WOOL_L1_LV_STOP_EN]);
   assign lowVoltageResetOut = lowVoltageResetReq && lowVoltageInhibitOn &&
      !latchOne_reg[`WOOL_L1_LV_RST_DIS];
   // Short delay leaves a window where the inhibit is not yet up
   assign stopRecoveryCycles =
      (latchOne_reg[`WOOL_L1_SHORT_REC] && !stopExitByReset && !exitReset_reg) ?
      `WOOL_REC_SHORT_CYC : `WOOL_REC_LONG_CYC;
   assign stopIllegalOpcode = !latchOne_reg[`WOOL_L1_STOP_EN];
   assign rcOscRun = !(stopMode && latchTwo[`WOOL_L2_RC_STOP_DIS]);
   assign crystalRun = !stopMode || latchTwo[`WOOL_L2_XTAL_STOP_EN];
   assign dividerBypass = latchTwo[`WOOL_L2_DIV_BYPASS] && !baseClockSelect;
   assign portHighNibbleLcd = latchTwo[`WOOL_L2_PORT_HI_LCD];
   assign portLowNibbleLcd = latchTwo[`WOOL_L2_PORT_LO_LCD];
   assign tripModeField = tripMode_reg;
   assign tripModeValid = (tripMode_reg == `WOOL_TRIP_3V) ||
      (tripMode_reg == `WOOL_TRIP_5V);
   assign latchOneWritten = oneDone_reg;
   assign latchTwoWritten = twoDone_reg;
endmodule

// >>> verification/wool_option_latches_chk.sv
`timescale 1ns/1ps
module wool_option_latches_chk (
   input wire clk, nrst, busWrStb, busRdStb, stopMode, stopExitByReset, baseClockSelect,
   input wire lowVoltageResetReq, lowVoltageResetOut, lowVoltageInhibitOn, dividerBypass,
   input wire watchdogRateBit, latchOneWritten,
   input wire [15:0] busAddr,
   input wire [7:0] busRdData,
   input wire [31:0] watchdogTimeoutCycles,
   input wire [12:0] stopRecoveryCycles,
   input wire [1:0] tripModeField
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_once; busWrStb && busAddr == 16'h001F |=> latchOneWritten; endproperty
   a_once: assert property (p_once) else $error("write lost");
   property p_keep; latchOneWritten |=> $stable(watchdogRateBit); endproperty
   a_keep: assert property (p_keep) else $error("latch moved");
   property p_rd; busRdStb && busAddr == 16'h001F |=> busRdData[7] == watchdogRateBit; endproperty
   a_rd: assert property (p_rd) else $error("bad read");
   property p_trip; busRdStb && busAddr == 16'h001D |=> busRdData[1:0] == tripModeField; endproperty
   a_trip: assert property (p_trip) else $error("bad trip");
   property p_wdog;
      watchdogTimeoutCycles == (watchdogRateBit ? 32'h0000_1FF0 : 32'h0003_FFF0); endproperty
   a_wdog: assert property (p_wdog) else $error("bad timeout");
   property p_lvr; lowVoltageResetOut |-> lowVoltageResetReq && lowVoltageInhibitOn; endproperty
   a_lvr: assert property (p_lvr) else $error("bad lv reset");
   property p_rec; (stopMode && stopExitByReset) [*2] |-> stopRecoveryCycles == 13'h1000; endproperty
   a_rec: assert property (p_rec) else $error("short exit");
   property p_byp; baseClockSelect |-> !dividerBypass; endproperty
   a_byp: assert property (p_byp) else $error("bypass");
   c_lvr: cover property (lowVoltageResetOut);
   c_short: cover property (stopRecoveryCycles == 13'h0020);
   c_byp: cover property (dividerBypass);
endmodule
bind wool_option_latches wool_option_latches_chk chk_i (.*);

// >>> verification/wool_tb.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 0, nrst = 0, porRst_n = 0, busWrStb = 0, busRdStb = 0, stopMode = 0;
   logic stopExitByReset = 0, lowVoltageResetReq = 0, baseClockSelect = 0;
   logic [15:0] busAddr = 0;
   logic [7:0] busWrData = 0, busRdData;
   logic [31:0] watchdogTimeoutCycles;
   logic [12:0] stopRecoveryCycles;
   logic [1:0] tripModeField;
   logic watchdogRateBit, watchdogEnable, lowVoltageInhibitOn, lowVoltageResetOut, rcOscRun;
   logic stopIllegalOpcode, crystalRun, dividerBypass, portHighNibbleLcd, portLowNibbleLcd;
   logic tripModeValid, latchOneWritten, latchTwoWritten;
   int miscompares, check_count;
   always #2.5 clk = ~clk;
   wool_option_latches uut (.*);
   task automatic chk(input logic [31:0] act, exp);
      check_count++;
      if (act !== exp) begin
         miscompares++;
         $display("Error %0t got %h exp %h", $time, act, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) {busWrStb, busAddr, busWrData} <= {1'b1, a, d};
      @(posedge clk) busWrStb <= 1'b0;
      #1;
   endtask
   // Read data lives one cycle only
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk) {busRdStb, busAddr} <= {1'b1, a};
      @(posedge clk) busRdStb <= 1'b0;
      #1 chk(busRdData, e);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_once;
      rd(16'h001F, 8'h10);
      rd(16'h001E, 8'h00);
      wr(16'h001F, 8'h8B);
      wr(16'h001F, 8'h00);
      rd(16'h001F, 8'h8B);
      chk(watchdogTimeoutCycles, 32'h0000_1FF0);
      chk({stopIllegalOpcode, watchdogEnable}, 2'b00);
   endtask
   task automatic t_lvi;
      @(posedge clk) lowVoltageResetReq <= 1'b1;
      #1 chk(lowVoltageResetOut, 1'b1);
      @(posedge clk) stopMode <= 1'b1;
      #1 chk(lowVoltageResetOut, 1'b0);
      // One edge in stop lets the reset-exit memory clear
      @(posedge clk);
      #1 chk(stopRecoveryCycles, 13'h0020);
      @(posedge clk) stopExitByReset <= 1'b1;
      #1 chk(stopRecoveryCycles, 13'h1000);
      repeat (2) @(posedge clk);
      #1 chk(stopRecoveryCycles, 13'h1000);
   endtask
   task automatic t_l2;
      @(posedge clk) baseClockSelect <= 1'b1;
      wr(16'h001D, 8'hED);
      rd(16'h001D, 8'hED);
      chk({rcOscRun, crystalRun, dividerBypass}, 3'b010);
      chk({portHighNibbleLcd, portLowNibbleLcd, tripModeField, tripModeValid}, 5'h1B);
      @(posedge clk) {stopMode, baseClockSelect, lowVoltageResetReq} <= 3'b000;
      #1 chk(dividerBypass, 1'b1);
   endtask
   // Warm reset keeps the trip field
   task automatic t_warm;
      @(posedge clk) nrst <= 1'b0;
      @(posedge clk) nrst <= 1'b1;
      rd(16'h001D, 8'h01);
      wr(16'h001D, 8'h0E);
      rd(16'h001D, 8'h0D);
   endtask
   task automatic conclude;
      if (miscompares == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      {nrst, porRst_n} <= 2'b11;
      t_once();
      t_lvi();
      t_l2();
      t_warm();
      conclude();
   end
endmodule
